// ==== sac_params.svh ====
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets.
// ----------------------------------------------------------------------------
// The printed offsets step by one, not by four, so they are kept as indices.
// Byte address = 4 * index, taken from the low bits of the index.
`define SAC_IDX_CONV_CONTROL     16'hFE58
`define SAC_IDX_CONV_MODE        16'hFE59
`define SAC_IDX_RESULT_LOW_BYTE  16'hFE5A
`define SAC_IDX_RESULT_HIGH_BYTE 16'hFE5B
`define SAC_IDX_IRQ_STATUS       16'hFE5C
`define SAC_IDX_IRQ_ENABLE       16'hFE5D
`define SAC_IDX_IRQ_CLEAR        16'hFE5E

// ----------------------------------------------------------------------------
// Reset values and field positions.
// ----------------------------------------------------------------------------
`define SAC_REG_RESET            8'h00
`define SAC_CTL_IRQ_EN_BIT       0
`define SAC_CTL_DONE_BIT         1
`define SAC_CTL_GO_BIT           2
`define SAC_CTL_CHSEL_LSB        4
`define SAC_MODE_RES_BIT         6
`define SAC_LOW_DIV_B2_BIT       0

// ----------------------------------------------------------------------------
// Timing figures, in thirds of a cycle plus the fixed overhead.
// ----------------------------------------------------------------------------
`define SAC_STEPS_12BIT          52
`define SAC_STEPS_8BIT           32
`define SAC_STEPS_EXTRA          2
`define SAC_TICKS_PER_BIT        4

`endif

// ==== sac_pkg.sv ====
package sac_pkg;

    // Sequencer states, one-hot.
    typedef enum logic [2:0] {
        SAC_IDLE   = 3'b001,
        SAC_RUN    = 3'b010,
        SAC_FINISH = 3'b100
    } sac_state_t;

    // Conversion resolution chosen by the mode register.
    typedef enum logic {
        SAC_RES_12 = 1'b0,
        SAC_RES_8  = 1'b1
    } sac_res_t;

endpackage

// ==== sac_divider.sv ====
`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// Conversion clock divider.
// ----------------------------------------------------------------------------
// Emits one-cycle enables at pclk rate divided by 2**sel while run is high.
module sac_divider #(
    parameter int CNT_W = 7
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             run,
    input  wire logic [2:0]       sel,
    output logic                  tick
);

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] mask;

    // Mask of counter bits that must all be one for a tick.
    assign mask = CNT_W'((8'h01 << sel) - 8'h01);
    assign tick = run && ((cnt_r & mask) == mask);

    // Free count restarted whenever the sequencer is idle, so each conversion
    // sees the same phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else if (!run) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + CNT_W'(1);
        end
    end

endmodule

// ==== sac_converter.sv ====
`timescale 1ns/100ps
`include "sac_params.svh"

module sac_converter #(
    parameter int RES_BITS = 12
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [15:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             comp_in,
    output logic [3:0]            channel_sel,
    output logic                  ref_enable,
    output logic [RES_BITS-1:0]   dac_code,
    output logic                  sample_hold,
    output logic                  irq
);

    // ------------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------------
    // Software-visible registers.
    logic [7:0]             conv_control_r;
    logic [7:0]             conv_mode_r;
    logic [7:0]             result_low_byte_r;
    logic [7:0]             result_high_byte_r;
    logic [1:0]             irq_status_r;
    logic [1:0]             irq_enable_r;

    // Sequencer and approximation state.
    sac_pkg::sac_state_t    state_r;
    sac_pkg::sac_res_t      res_r;
    logic [RES_BITS-1:0]    sar_r;
    logic [RES_BITS-1:0]    trial_r;
    logic [7:0]             step_r;
    logic [1:0]             third_r;

    // Comparator synchroniser.
    logic                   comp_meta_r;
    logic                   comp_sync_r;

    // Decode and timing helpers.
    logic                   tick;
    logic                   wr_en;
    logic                   rd_en;
    logic [13:0]            word_idx;
    logic                   addr_hit;
    logic                   done_set;
    logic                   go_bit;
    logic [2:0]             div_sel;
    logic [7:0]             step_total;
    logic                   steps_done;
    logic                   bit_tick;
    logic [31:0]            rd_mux;

    // ------------------------------------------------------------------------
    // APB access decode.
    // ------------------------------------------------------------------------
    // Zero wait states: every transfer completes in its first access cycle.
    // Only the low fourteen index bits fit on the 16-bit bus, so the map is
    // matched on paddr[15:2] and the upper index bits are dropped.
    assign pready   = 1'b1;
    assign wr_en    = psel && penable && pwrite;
    assign rd_en    = psel && !penable && !pwrite;  // Read setup cycle.
    assign word_idx = paddr[15:2];
    assign addr_hit = (word_idx >= 14'(`SAC_IDX_CONV_CONTROL))
                   && (word_idx <= 14'(`SAC_IDX_IRQ_CLEAR));
    assign pslverr  = psel && penable && !addr_hit;
    assign go_bit   = conv_control_r[`SAC_CTL_GO_BIT];

    // ------------------------------------------------------------------------
    // Comparator synchroniser.
    // ------------------------------------------------------------------------
    // The analog comparator is asynchronous to pclk, so it is resynchronised.
    // The two flops delay it by two cycles; a bit is judged only four steps
    // after its trial code is set, which covers that delay.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comp_meta_r <= 1'b0;
            comp_sync_r <= 1'b0;
        end else begin
            comp_meta_r <= comp_in;
            comp_sync_r <= comp_meta_r;
        end
    end

    // ------------------------------------------------------------------------
    // Conversion clock.
    // ------------------------------------------------------------------------
    assign div_sel = {result_low_byte_r[`SAC_LOW_DIV_B2_BIT],
                      conv_mode_r[1:0]};

    // Restarted at each run so every conversion sees the same phase.
    sac_divider #(
        .CNT_W (7)
    ) u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (state_r == sac_pkg::SAC_RUN),
        .sel     (div_sel),
        .tick    (tick)
    );

    // ------------------------------------------------------------------------
    // Conversion timing.
    // ------------------------------------------------------------------------
    // pclk is the only clock, so one pclk cycle stands for a third of the
    // base cycle. The ratio 1/2**sel stretches each of the 52 (or 32) steps
    // to 2**sel cycles; the fixed overhead of two then runs at full rate.
    // The doubled first run after reset or a mode change is not modelled;
    // software that depends on it must wait the longer time itself.
    assign step_total = (res_r == sac_pkg::SAC_RES_8) ? 8'(`SAC_STEPS_8BIT)
                                                      : 8'(`SAC_STEPS_12BIT);
    assign steps_done = (step_r == step_total);

    // Four steps per bit fit twelve bits into 52 steps and eight into 32,
    // and leave the comparator synchroniser time to settle.
    assign bit_tick = tick && !steps_done
                   && ((step_r % 8'(`SAC_TICKS_PER_BIT)) == 8'(`SAC_TICKS_PER_BIT - 1));

    // Overhead counter: counts the cycles after the last step, on pclk.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            third_r <= 2'h0;
        end else if (state_r != sac_pkg::SAC_RUN) begin
            third_r <= 2'h0;
        end else if (steps_done) begin
            third_r <= third_r + 2'h1;
        end
    end

    // ------------------------------------------------------------------------
    // Sequencer.
    // ------------------------------------------------------------------------
    // A conversion starts when the go bit is seen set while idle.
    // Clearing go during a run aborts it: no result is kept and no flag set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= sac_pkg::SAC_IDLE;
        end else begin
            unique case (state_r)
                sac_pkg::SAC_IDLE: begin
                    if (go_bit) begin
                        state_r <= sac_pkg::SAC_RUN;
                    end
                end
                sac_pkg::SAC_RUN: begin
                    if (!go_bit) begin
                        state_r <= sac_pkg::SAC_IDLE;
                    end else if (steps_done && third_r == 2'(`SAC_STEPS_EXTRA - 1)) begin
                        state_r <= sac_pkg::SAC_FINISH;
                    end
                end
                sac_pkg::SAC_FINISH: begin
                    state_r <= sac_pkg::SAC_IDLE;
                end
            endcase
        end
    end

    // Step counter and approximation register. Bits are resolved MSB first,
    // one every four steps, over the first 48 (or 32) steps; the remaining
    // steps are settling time.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_r  <= 8'h00;
            sar_r   <= '0;
            trial_r <= '0;
            res_r   <= sac_pkg::SAC_RES_12;
        end else if (state_r == sac_pkg::SAC_IDLE) begin
            step_r  <= 8'h00;
            sar_r   <= '0;
            trial_r <= {1'b1, {(RES_BITS-1){1'b0}}};
            res_r   <= sac_pkg::sac_res_t'(conv_mode_r[`SAC_MODE_RES_BIT]);
        end else if (state_r == sac_pkg::SAC_RUN && tick && !steps_done) begin
            step_r <= step_r + 8'h01;
            if (bit_tick && trial_r != '0) begin
                if (comp_sync_r) begin
                    sar_r <= sar_r | trial_r;
                end
                if (res_r == sac_pkg::SAC_RES_8
                    && trial_r == RES_BITS'(1) << (RES_BITS - 8)) begin
                    trial_r <= '0;
                end else begin
                    trial_r <= trial_r >> 1;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Outputs to the analog side.
    // ------------------------------------------------------------------------
    // Some upper channel codes are barred for software; the field is passed
    // on as written and the far side decides what it means.
    assign done_set    = (state_r == sac_pkg::SAC_FINISH);
    assign dac_code    = sar_r | trial_r;
    assign ref_enable  = (state_r == sac_pkg::SAC_RUN);
    assign sample_hold = (state_r == sac_pkg::SAC_RUN);
    assign channel_sel = conv_control_r[7:4];

    // ------------------------------------------------------------------------
    // Register file.
    // ------------------------------------------------------------------------
    // Control: go clears itself and the done flag sets at the end; a set
    // arriving together with a software clear wins.
    // Fixed bit 3 is stored as written; software keeps it zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_control_r <= `SAC_REG_RESET;
        end else begin
            if (wr_en && word_idx == 14'(`SAC_IDX_CONV_CONTROL)) begin
                conv_control_r <= pwdata[7:0];
            end
            if (done_set) begin
                conv_control_r[`SAC_CTL_GO_BIT]   <= 1'b0;
                conv_control_r[`SAC_CTL_DONE_BIT] <= 1'b1;
            end
        end
    end

    // Mode: resolution select and the two low divider bits. The fixed bits
    // are stored as written and read back, so software sees what it wrote;
    // keeping them zero is left to software.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_mode_r <= `SAC_REG_RESET;
        end else if (wr_en && word_idx == 14'(`SAC_IDX_CONV_MODE)) begin
            conv_mode_r <= pwdata[7:0];
        end
    end

    // Results change as the done flag sets or on a software write; a software write in the same
    // cycle yields to the result.
    // In eight-bit mode the low byte keeps its old nibble and divider bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_high_byte_r <= `SAC_REG_RESET;
            result_low_byte_r  <= `SAC_REG_RESET;
        end else begin
            if (wr_en && word_idx == 14'(`SAC_IDX_RESULT_HIGH_BYTE)) begin
                result_high_byte_r <= pwdata[7:0];
            end
            if (wr_en && word_idx == 14'(`SAC_IDX_RESULT_LOW_BYTE)) begin
                result_low_byte_r <= pwdata[7:0];
            end
            if (done_set) begin
                result_high_byte_r <= sar_r[RES_BITS-1 -: 8];
                if (res_r == sac_pkg::SAC_RES_12) begin
                    result_low_byte_r[7:4] <= sar_r[3:0];
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt status, enable and clear.
    // ------------------------------------------------------------------------
    // Bit 0 mirrors conversion end; set beats a clear in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_r <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (i == 0 && done_set) begin
                    irq_status_r[i] <= 1'b1;
                end else if (wr_en && word_idx == 14'(`SAC_IDX_IRQ_CLEAR) && pwdata[i]) begin
                    irq_status_r[i] <= 1'b0;
                end
            end
        end
    end

    // Interrupt enable, of the same layout as the status register; bit 1 is
    // stored as written, though its status bit is a spare that nothing sets.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable_r <= 2'h0;
        end else if (wr_en && word_idx == 14'(`SAC_IDX_IRQ_ENABLE)) begin
            irq_enable_r <= pwdata[1:0];
        end
    end

    // Level interrupt from the done flag and its enable, or from the sticky
    // status through the enable register.
    // Either path alone raises it, so both enables gate the same line.
    assign irq = (conv_control_r[`SAC_CTL_DONE_BIT] && conv_control_r[`SAC_CTL_IRQ_EN_BIT])
              || |(irq_status_r & irq_enable_r);

    // ------------------------------------------------------------------------
    // Read data.
    // ------------------------------------------------------------------------
    // Read multiplexer; the clear register and unmapped indices read zero.
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (word_idx == 14'(`SAC_IDX_CONV_CONTROL)) begin
            rd_mux[7:0] = conv_control_r;
        end else if (word_idx == 14'(`SAC_IDX_CONV_MODE)) begin
            rd_mux[7:0] = conv_mode_r;
        end else if (word_idx == 14'(`SAC_IDX_RESULT_LOW_BYTE)) begin
            rd_mux[7:0] = result_low_byte_r;
        end else if (word_idx == 14'(`SAC_IDX_RESULT_HIGH_BYTE)) begin
            rd_mux[7:0] = result_high_byte_r;
        end else if (word_idx == 14'(`SAC_IDX_IRQ_STATUS)) begin
            rd_mux[1:0] = irq_status_r;
        end else if (word_idx == 14'(`SAC_IDX_IRQ_ENABLE)) begin
            rd_mux[1:0] = irq_enable_r;
        end
    end

    // Read data registered at the setup cycle so it is stable in access.
    // A register updated in the setup cycle itself shows on the next read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= rd_mux;
        end
    end

endmodule

// ==== sac_converter_props.sv ====
`timescale 1ns/100ps
`include "sac_params.svh"

// ----------------------------------------------------------------------------
// Port checker for the converter control block.
// ----------------------------------------------------------------------------
module sac_converter_props #(
    parameter int RES_BITS = 12
) (
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [15:0]         paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic                comp_in,
    input wire logic [3:0]          channel_sel,
    input wire logic                ref_enable,
    input wire logic [RES_BITS-1:0] dac_code,
    input wire logic                sample_hold,
    input wire logic                irq
);
    logic [12:0] ref_cnt_r;
    logic        any_wr;
    logic        ctl_wr;
    logic        go_wr;
    logic        mapped;

    // Access decodes; the index is the byte address divided by four.
    assign any_wr = psel && penable && pwrite;
    assign ctl_wr = any_wr && (paddr[15:2] == 14'(`SAC_IDX_CONV_CONTROL));
    assign go_wr  = ctl_wr && pwdata[2];
    assign mapped = (paddr[15:2] >= 14'(`SAC_IDX_CONV_CONTROL))
                 && (paddr[15:2] <= 14'(`SAC_IDX_IRQ_CLEAR));

    // Length of the current reference-on stretch, so a hung run is caught.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_cnt_r <= 13'h0000;
        end else if (ref_enable) begin
            ref_cnt_r <= ref_cnt_r + 13'h0001;
        end else begin
            ref_cnt_r <= 13'h0000;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ref_on_go: assert property ($rose(ref_enable) |-> $past(go_wr) || $past(go_wr, 2))
        else $error("reference on without a go write");
    a_chan_sel_field: assert property (ctl_wr |=> channel_sel == $past(pwdata[7:4]))
        else $error("channel select does not follow the control field");
    a_irq_fall_cause: assert property ($fell(irq) |-> $past(any_wr))
        else $error("interrupt dropped without a software write");
    a_irq_rise_cause: assert property ($rose(irq) |->
            $past(any_wr) || $past(ref_enable, 2) || $past(ref_enable, 3))
        else $error("interrupt raised without a conversion end or write");
    a_ref_min_time: assert property ($rose(ref_enable) |-> ref_enable [*8])
        else $error("conversion shorter than the shortest time");
    a_ref_max_time: assert property (ref_cnt_r <= 13'(`SAC_STEPS_12BIT * 128 + `SAC_STEPS_EXTRA))
        else $error("conversion longer than the longest time");
    a_unmapped_err: assert property (psel && penable && !mapped |->
            pslverr && (pwrite || prdata == 32'h0000_0000))
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (psel && penable && mapped |-> !pslverr && pready)
        else $error("mapped access refused or stalled");
endmodule

bind sac_converter sac_converter_props #(.RES_BITS(RES_BITS)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comp_in(comp_in), .channel_sel(channel_sel), .ref_enable(ref_enable),
    .dac_code(dac_code), .sample_hold(sample_hold), .irq(irq));

// ==== sac_analog_model.sv ====
`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// Analog side: sixteen input levels and the comparator.
// ----------------------------------------------------------------------------
module sac_analog_model (
    input wire logic        pclk,
    input wire logic [3:0]  channel_sel,
    input wire logic        ref_enable,
    input wire logic [11:0] dac_code,
    output logic            comp_in
);
    logic [11:0] level;
    logic        idle_r = 1'b0;

    // Each pin carries a level the bench can predict from its number.
    assign level = {channel_sel, ~channel_sel, channel_sel ^ 4'h6};

    // With no reference the output means nothing, so it toggles rather than
    // hold a value that a careless converter could still get right.
    always_ff @(posedge pclk) begin
        idle_r <= ~idle_r;
    end

    // Comparator is high while the input is at or above the trial level.
    assign comp_in = ref_enable ? (level >= dac_code) : idle_r;
endmodule

// ==== sac_converter_bench.sv ====
`timescale 1ns/100ps
`include "sac_params.svh"

`define SAC_CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
    $display("Error t=%0t got %h exp %h", $time, got, exp); end end

// ----------------------------------------------------------------------------
// Register-level regression of the converter control block.
// ----------------------------------------------------------------------------
module sac_converter_bench;
    localparam logic [15:0] I_CTL = `SAC_IDX_CONV_CONTROL;
    localparam logic [15:0] I_MOD = `SAC_IDX_CONV_MODE;
    localparam logic [15:0] I_LOW = `SAC_IDX_RESULT_LOW_BYTE;
    localparam logic [15:0] I_HI  = `SAC_IDX_RESULT_HIGH_BYTE;
    localparam logic [15:0] I_ST  = `SAC_IDX_IRQ_STATUS;
    localparam logic [15:0] I_EN  = `SAC_IDX_IRQ_ENABLE;
    localparam logic [15:0] I_CLR = `SAC_IDX_IRQ_CLEAR;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr;
    logic        comp_in, ref_enable, sample_hold, irq, err;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0]  channel_sel, ch;
    logic [11:0] dac_code, v;
    logic [7:0]  rv, hi_prev;
    logic [2:0]  s3;
    realtime     t_on, t_off;
    int          miscompares = 0;
    int          checks_done = 0;
    int          base, busy;

    // Free-running clock; reference edges are timed to measure conversions.
    always #25 pclk = ~pclk;
    always @(posedge ref_enable) t_on = $realtime;
    always @(negedge ref_enable) t_off = $realtime;

    sac_converter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .comp_in(comp_in), .channel_sel(channel_sel),
        .ref_enable(ref_enable), .dac_code(dac_code), .sample_hold(sample_hold), .irq(irq));
    sac_analog_model u_analog (.pclk(pclk), .channel_sel(channel_sel),
        .ref_enable(ref_enable), .dac_code(dac_code), .comp_in(comp_in));

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One APB transfer; the request holds until pready is seen high.
    task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx[13:0], 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 100);
        if (pready !== 1'b1) begin miscompares++; test_done; end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] idx);
        xfer(1'b0, idx, 8'h00);
        rv = q[7:0];
    endtask

    task automatic settle;
        @(posedge pclk);
        #1;
    endtask

    // Start a run, check the high result byte holds meanwhile, then poll go until it clears.
    task automatic convert(input logic [7:0] ctl);
        int n;
        xfer(1'b1, I_CTL, ctl);
        rd(I_HI);
        `SAC_CHK(rv, hi_prev);
        `SAC_CHK({ref_enable, sample_hold}, 2'b11);
        n = 0;
        do begin rd(I_CTL); n++; end while (rv[2] !== 1'b0 && n < 3000);
        if (rv[2] !== 1'b0) begin miscompares++; test_done; end
        busy = int'((t_off - t_on) / 50.0);
        `SAC_CHK(busy >= base - 2 && busy <= base + 4, 1'b1);
    endtask

    // Watchdog against a hang anywhere in the sequence.
    initial begin
        repeat (100000) @(posedge pclk);
        miscompares++;
        test_done;
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        hi_prev = 8'h00;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            xfer(1'b0, I_CTL + 16'(i), 8'h00);
            `SAC_CHK(q, 32'h0000_0000);
        end
        xfer(1'b0, 16'hFE60, 8'h00);
        `SAC_CHK({err, q}, 33'h1_0000_0000);
        $display("test reset values done");
        for (int s = 0; s < 8; s++) begin
            ch = 4'(s + 2);
            s3 = 3'(s);
            v = {ch, ~ch, ch ^ 4'h6};
            base = `SAC_STEPS_12BIT * (1 << s) + `SAC_STEPS_EXTRA;
            xfer(1'b1, I_LOW, {7'h00, s3[2]});
            xfer(1'b1, I_MOD, {6'h00, s3[1:0]});
            convert({ch, 4'h4});
            `SAC_CHK(channel_sel, ch);
            rd(I_HI);
            `SAC_CHK(rv, v[11:4]);
            rd(I_LOW);
            `SAC_CHK(rv, {v[3:0], 3'h0, s3[2]});
            rd(I_CTL);
            `SAC_CHK(rv, {ch, 4'h2});
            rd(I_ST);
            `SAC_CHK(rv, 8'h01);
            hi_prev = v[11:4];
            xfer(1'b1, I_CTL, {ch, 4'h0});
            xfer(1'b1, I_CLR, 8'h01);
        end
        $display("test ratio sweep done");
        base = `SAC_STEPS_8BIT + `SAC_STEPS_EXTRA;
        xfer(1'b1, I_LOW, 8'hA0);
        xfer(1'b1, I_MOD, 8'h40);
        convert(8'h54);
        rd(I_HI);
        `SAC_CHK(rv, 8'h5A);
        rd(I_LOW);
        `SAC_CHK(rv, 8'hA0);
        $display("test eight bit done");
        settle;
        `SAC_CHK(irq, 1'b0);
        xfer(1'b1, I_EN, 8'h01);
        settle;
        `SAC_CHK(irq, 1'b1);
        xfer(1'b1, I_CLR, 8'h01);
        rd(I_ST);
        `SAC_CHK(rv, 8'h00);
        settle;
        `SAC_CHK(irq, 1'b0);
        xfer(1'b1, I_CTL, 8'h53);
        settle;
        `SAC_CHK(irq, 1'b1);
        xfer(1'b1, I_CTL, 8'h50);
        settle;
        `SAC_CHK(irq, 1'b0);
        xfer(1'b1, I_EN, 8'h00);
        $display("test interrupt done");
        xfer(1'b1, I_MOD, 8'h03);
        xfer(1'b1, I_LOW, 8'h01);
        xfer(1'b1, I_CTL, 8'h74);
        repeat (20) @(posedge pclk);
        xfer(1'b1, I_CTL, 8'h70);
        settle;
        settle;
        `SAC_CHK({ref_enable, sample_hold}, 2'b00);
        rd(I_ST);
        `SAC_CHK(rv, 8'h00);
        rd(I_HI);
        `SAC_CHK(rv, 8'h5A);
        $display("test abort done");
        test_done;
    end
endmodule
